// ==== psrc_top.sv ====
// peripheral soft reset control: axi4-lite register slave and per-peripheral reset outputs
//
// Chosen here: the AXI4-Lite register port.
`timescale 1ns/1ps
module psrc_top
(
	input  wire logic                             mclk_i,
	input  wire logic                             reset_n_i,
	input  wire psrc_pkg::psrc_axi_req_t          axi_req_i,
	output psrc_pkg::psrc_axi_rsp_t               axi_rsp_o,
	input  wire logic [psrc_pkg::PSRC_PERIPH_CNT-1:0] periph_clk_i,
	output logic [psrc_pkg::PSRC_PERIPH_CNT-1:0]  periph_rst_o
);
	import psrc_pkg::*;

	typedef struct packed {
		logic [PSRC_DATA_W-1:0]     ctrl_one;
		logic [PSRC_DATA_W-1:0]     ctrl_two;
		logic [PSRC_ADDR_W-1:0]     aw_addr;
		logic                       aw_got;
		logic [PSRC_DATA_W-1:0]     w_data;
		logic [PSRC_STRB_W-1:0]     w_strb;
		logic                       w_got;
		logic                       awready;
		logic                       wready;
		logic                       bvalid;
		logic [1:0]                 bresp;
		logic                       arready;
		logic                       rvalid;
		logic [PSRC_DATA_W-1:0]     rdata;
		logic [1:0]                 rresp;
		logic [PSRC_PERIPH_CNT-1:0] stat_meta;
		logic [PSRC_PERIPH_CNT-1:0] stat_sync;
	} psrc_state_t;

	localparam psrc_state_t PSRC_STATE_RST = '{
		ctrl_one  : PSRC_CTRL_ONE_RST,
		ctrl_two  : PSRC_CTRL_TWO_RST,
		aw_addr   : '0,
		aw_got    : 1'b0,
		w_data    : '0,
		w_strb    : '0,
		w_got     : 1'b0,
		awready   : 1'b0,
		wready    : 1'b0,
		bvalid    : 1'b0,
		bresp     : PSRC_RESP_OKAY,
		arready   : 1'b0,
		rvalid    : 1'b0,
		rdata     : '0,
		rresp     : PSRC_RESP_OKAY,
		stat_meta : '0,
		stat_sync : '0
	};

	psrc_state_t                st_q;
	psrc_state_t                st_d;
	psrc_sel_t                  wr_sel;
	psrc_sel_t                  rd_sel;
	logic [PSRC_PERIPH_CNT-1:0] assert_req;
	logic [PSRC_DATA_W-1:0]     stat_one;
	logic [PSRC_DATA_W-1:0]     stat_two;

	// address decode shared by the write and read paths
	function automatic psrc_sel_t psrc_decode(input logic [PSRC_ADDR_W-1:0] addr);
		psrc_sel_t sel;
		if (addr == PSRC_CTRL_ONE_OFS)
		begin
			sel = PSRC_SEL_CTRL_ONE;
		end
		else if (addr == PSRC_CTRL_TWO_OFS)
		begin
			sel = PSRC_SEL_CTRL_TWO;
		end
		else if (addr == PSRC_STAT_ONE_OFS)
		begin
			sel = PSRC_SEL_STAT_ONE;
		end
		else if (addr == PSRC_STAT_TWO_OFS)
		begin
			sel = PSRC_SEL_STAT_TWO;
		end
		else
		begin
			sel = PSRC_SEL_NONE;
		end
		return sel;
	endfunction : psrc_decode

	// byte-lane merge, then reserved positions forced back to zero
	function automatic logic [PSRC_DATA_W-1:0] psrc_merge(
		input logic [PSRC_DATA_W-1:0] old_val,
		input logic [PSRC_DATA_W-1:0] new_val,
		input logic [PSRC_STRB_W-1:0] strb,
		input logic [PSRC_DATA_W-1:0] mask
	);
		logic [PSRC_DATA_W-1:0] res;
		res = old_val;
		for (int b = 0; b < PSRC_STRB_W; b++)
		begin
			if (strb[b])
			begin
				res[b*8 +: 8] = new_val[b*8 +: 8];
			end
		end
		return res & mask;
	endfunction : psrc_merge

	// status words put each synchronised output back at its control bit position
	always_comb
	begin
		stat_one = '0;
		stat_two = '0;
		for (int i = 0; i < PSRC_ONE_CNT; i++)
		begin
			stat_one[PSRC_ONE_POS[i]] = st_q.stat_sync[i];
		end
		for (int j = 0; j < PSRC_TWO_CNT; j++)
		begin
			stat_two[PSRC_TWO_POS[j]] = st_q.stat_sync[PSRC_ONE_CNT + j];
		end
	end

	always_comb
	begin
		st_d = st_q;
		wr_sel = psrc_decode(st_q.aw_addr);
		rd_sel = psrc_decode(axi_req_i.araddr);

		// write address and data are taken independently, in either order
		if (axi_req_i.awvalid && st_q.awready)
		begin
			st_d.aw_addr = axi_req_i.awaddr;
			st_d.aw_got = 1'b1;
		end
		if (axi_req_i.wvalid && st_q.wready)
		begin
			st_d.w_data = axi_req_i.wdata;
			st_d.w_strb = axi_req_i.wstrb;
			st_d.w_got = 1'b1;
		end

		if (st_q.bvalid && axi_req_i.bready)
		begin
			st_d.bvalid = 1'b0;
		end

		// commit one cycle after both halves are held
		if (st_q.aw_got && st_q.w_got && !st_q.bvalid)
		begin
			st_d.aw_got = 1'b0;
			st_d.w_got = 1'b0;
			st_d.bvalid = 1'b1;
			st_d.bresp = PSRC_RESP_OKAY;
			if (wr_sel == PSRC_SEL_CTRL_ONE)
			begin
				// a one sets and a zero releases the matching reset
				st_d.ctrl_one = psrc_merge(st_q.ctrl_one, st_q.w_data, st_q.w_strb,
					PSRC_CTRL_ONE_MASK); // [R01] [R02] [R14] [R15]
			end
			else if (wr_sel == PSRC_SEL_CTRL_TWO)
			begin
				st_d.ctrl_two = psrc_merge(st_q.ctrl_two, st_q.w_data, st_q.w_strb,
					PSRC_CTRL_TWO_MASK); // [R01] [R02] [R14] [R15]
			end
			else if (wr_sel == PSRC_SEL_STAT_ONE || wr_sel == PSRC_SEL_STAT_TWO)
			begin
				// status words are read-only; the write is dropped quietly
				st_d.bresp = PSRC_RESP_OKAY;
			end
			else
			begin
				st_d.bresp = PSRC_RESP_SLVERR;
			end
		end

		if (st_q.rvalid && axi_req_i.rready)
		begin
			st_d.rvalid = 1'b0;
		end

		if (axi_req_i.arvalid && st_q.arready)
		begin
			st_d.rvalid = 1'b1;
			st_d.rresp = PSRC_RESP_OKAY;
			if (rd_sel == PSRC_SEL_CTRL_ONE)
			begin
				st_d.rdata = st_q.ctrl_one; // [R03]
			end
			else if (rd_sel == PSRC_SEL_CTRL_TWO)
			begin
				st_d.rdata = st_q.ctrl_two; // [R03]
			end
			else if (rd_sel == PSRC_SEL_STAT_ONE)
			begin
				st_d.rdata = stat_one;
			end
			else if (rd_sel == PSRC_SEL_STAT_TWO)
			begin
				st_d.rdata = stat_two;
			end
			else
			begin
				st_d.rdata = '0;
				st_d.rresp = PSRC_RESP_SLVERR;
			end
		end

		// one write and one read outstanding at most
		st_d.awready = !st_d.aw_got && !st_d.bvalid;
		st_d.wready = !st_d.w_got && !st_d.bvalid;
		st_d.arready = !st_d.rvalid;

		// outputs come back from foreign domains, so two flops before status
		st_d.stat_meta = periph_rst_o;
		st_d.stat_sync = st_q.stat_meta;
	end

	always_ff @(posedge mclk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			st_q <= PSRC_STATE_RST; // [R03]
		end
		else
		begin
			st_q <= st_d;
		end
	end

	// register one bits to outputs 0 .. 15
	genvar gi;
	generate
		for (gi = 0; gi < PSRC_ONE_CNT; gi++)
		begin : g_one
			// system reset also holds peripherals, so outputs are defined from power-up
			assign assert_req[gi] = st_q.ctrl_one[PSRC_ONE_POS[gi]] | ~reset_n_i; // [R04] [R05] [R06] [R07]

			psrc_rst_sync u_sync
			(
				.dst_clk_i (periph_clk_i[gi]),
				.assert_i  (assert_req[gi]),
				.rst_o     (periph_rst_o[gi])
			); // [R08] [R09] [R10] [R11] [R15]
		end
	endgenerate

	// register two bits to outputs 16 .. 20
	genvar gj;
	generate
		for (gj = 0; gj < PSRC_TWO_CNT; gj++)
		begin : g_two
			assign assert_req[PSRC_ONE_CNT + gj] = st_q.ctrl_two[PSRC_TWO_POS[gj]] | ~reset_n_i; // [R12] [R13]

			psrc_rst_sync u_sync
			(
				.dst_clk_i (periph_clk_i[PSRC_ONE_CNT + gj]),
				.assert_i  (assert_req[PSRC_ONE_CNT + gj]),
				.rst_o     (periph_rst_o[PSRC_ONE_CNT + gj])
			); // [R15]
		end
	endgenerate

	// a held flag stalls its ready, so an early address waits for its data
	assign axi_rsp_o.awready = st_q.awready;
	assign axi_rsp_o.wready  = st_q.wready;
	assign axi_rsp_o.bvalid  = st_q.bvalid;
	assign axi_rsp_o.bresp   = st_q.bresp;
	assign axi_rsp_o.arready = st_q.arready;
	assign axi_rsp_o.rvalid  = st_q.rvalid;
	assign axi_rsp_o.rdata   = st_q.rdata;
	assign axi_rsp_o.rresp   = st_q.rresp;

endmodule : psrc_top

// ==== psrc_pkg.sv ====
// package: register map, field layout and bus carriers of the peripheral soft reset control
// Function
// R01: writing one to an implemented bit asserts that peripheral's asynchronous reset output
// R02: the reset output stays asserted until software writes zero to its bit
// R03: both control registers are 32-bit read/write and clear to zero on system reset
// R04: register one bit 28 resets the analog-to-digital converter controller
// R05: register one bit 22 resets the comparator pair controller
// R06: register one bits 21 and 20 reset pulse modulators b and a
// R07: register one bits 18, 17, 16 reset serial ports c, b, a
// R08: register one bits 13 and 12 reset synchronous serial b and a
// R09: register one bits 9 and 8 reset two-wire controllers b and a
// R10: register one bits 5, 4, 3, 2 reset timers d, c, b, a
// R11: register one bit 1 resets the port input/output controller
// R12: register two bits 10, 9, 8 reset universal serial c, b, a
// R13: register two bits 1 and 0 reset smart card b and a
// R14: reserved bits of both registers drive no reset
// R15: reserved bits read zero, ignore writes; each reset release synchronised to its peripheral
package psrc_pkg;

	localparam int unsigned PSRC_ADDR_W = 8;
	localparam int unsigned PSRC_DATA_W = 32;
	localparam int unsigned PSRC_STRB_W = PSRC_DATA_W / 8;

	// byte addresses of the registers
	localparam logic [PSRC_ADDR_W-1:0] PSRC_CTRL_ONE_OFS = 8'h0c;
	localparam logic [PSRC_ADDR_W-1:0] PSRC_CTRL_TWO_OFS = 8'h10;
	localparam logic [PSRC_ADDR_W-1:0] PSRC_STAT_ONE_OFS = 8'h40;
	localparam logic [PSRC_ADDR_W-1:0] PSRC_STAT_TWO_OFS = 8'h44;

	localparam logic [PSRC_DATA_W-1:0] PSRC_CTRL_ONE_RST = 32'h0000_0000;
	localparam logic [PSRC_DATA_W-1:0] PSRC_CTRL_TWO_RST = 32'h0000_0000;

	// writable bit masks; every other position is reserved
	localparam logic [PSRC_DATA_W-1:0] PSRC_CTRL_ONE_MASK = 32'h1077_333e;
	localparam logic [PSRC_DATA_W-1:0] PSRC_CTRL_TWO_MASK = 32'h0000_0703;

	// register one bit positions
	localparam int unsigned PSRC_CONVERTER_RESET_BIT = 28;
	localparam int unsigned PSRC_COMPARATOR_PAIR_RESET_BIT = 22;
	localparam int unsigned PSRC_PULSE_MOD_B_RESET_BIT = 21;
	localparam int unsigned PSRC_PULSE_MOD_A_RESET_BIT = 20;
	localparam int unsigned PSRC_SERIAL_PORT_C_RESET_BIT = 18;
	localparam int unsigned PSRC_SERIAL_PORT_B_RESET_BIT = 17;
	localparam int unsigned PSRC_SERIAL_PORT_A_RESET_BIT = 16;
	localparam int unsigned PSRC_SYNC_SERIAL_B_RESET_BIT = 13;
	localparam int unsigned PSRC_SYNC_SERIAL_A_RESET_BIT = 12;
	localparam int unsigned PSRC_TWO_WIRE_B_RESET_BIT = 9;
	localparam int unsigned PSRC_TWO_WIRE_A_RESET_BIT = 8;
	localparam int unsigned PSRC_TIMER_D_RESET_BIT = 5;
	localparam int unsigned PSRC_TIMER_C_RESET_BIT = 4;
	localparam int unsigned PSRC_TIMER_B_RESET_BIT = 3;
	localparam int unsigned PSRC_TIMER_A_RESET_BIT = 2;
	localparam int unsigned PSRC_PORT_IO_RESET_BIT = 1;

	// register two bit positions
	localparam int unsigned PSRC_UNIVERSAL_SERIAL_C_RESET_BIT = 10;
	localparam int unsigned PSRC_UNIVERSAL_SERIAL_B_RESET_BIT = 9;
	localparam int unsigned PSRC_UNIVERSAL_SERIAL_A_RESET_BIT = 8;
	localparam int unsigned PSRC_SMART_CARD_B_RESET_BIT = 1;
	localparam int unsigned PSRC_SMART_CARD_A_RESET_BIT = 0;

	localparam int unsigned PSRC_ONE_CNT = 16;
	localparam int unsigned PSRC_TWO_CNT = 5;
	localparam int unsigned PSRC_PERIPH_CNT = PSRC_ONE_CNT + PSRC_TWO_CNT;

	// reset output index i maps to these register bits, register one first
	localparam int unsigned PSRC_ONE_POS [PSRC_ONE_CNT] = '{
		PSRC_PORT_IO_RESET_BIT, PSRC_TIMER_A_RESET_BIT, PSRC_TIMER_B_RESET_BIT, PSRC_TIMER_C_RESET_BIT,
		PSRC_TIMER_D_RESET_BIT, PSRC_TWO_WIRE_A_RESET_BIT, PSRC_TWO_WIRE_B_RESET_BIT,
		PSRC_SYNC_SERIAL_A_RESET_BIT, PSRC_SYNC_SERIAL_B_RESET_BIT, PSRC_SERIAL_PORT_A_RESET_BIT,
		PSRC_SERIAL_PORT_B_RESET_BIT, PSRC_SERIAL_PORT_C_RESET_BIT, PSRC_PULSE_MOD_A_RESET_BIT,
		PSRC_PULSE_MOD_B_RESET_BIT, PSRC_COMPARATOR_PAIR_RESET_BIT, PSRC_CONVERTER_RESET_BIT};
	localparam int unsigned PSRC_TWO_POS [PSRC_TWO_CNT] = '{
		PSRC_SMART_CARD_A_RESET_BIT, PSRC_SMART_CARD_B_RESET_BIT, PSRC_UNIVERSAL_SERIAL_A_RESET_BIT,
		PSRC_UNIVERSAL_SERIAL_B_RESET_BIT, PSRC_UNIVERSAL_SERIAL_C_RESET_BIT};

	localparam logic [1:0] PSRC_RESP_OKAY = 2'h0;
	localparam logic [1:0] PSRC_RESP_SLVERR = 2'h2;

	typedef enum logic [2:0] {
		PSRC_SEL_CTRL_ONE,
		PSRC_SEL_CTRL_TWO,
		PSRC_SEL_STAT_ONE,
		PSRC_SEL_STAT_TWO,
		PSRC_SEL_NONE
	} psrc_sel_t;

	// master to slave
	typedef struct packed {
		logic [PSRC_ADDR_W-1:0] awaddr;
		logic                   awvalid;
		logic [PSRC_DATA_W-1:0] wdata;
		logic [PSRC_STRB_W-1:0] wstrb;
		logic                   wvalid;
		logic                   bready;
		logic [PSRC_ADDR_W-1:0] araddr;
		logic                   arvalid;
		logic                   rready;
	} psrc_axi_req_t;

	// slave to master
	typedef struct packed {
		logic                   awready;
		logic                   wready;
		logic [1:0]             bresp;
		logic                   bvalid;
		logic                   arready;
		logic [PSRC_DATA_W-1:0] rdata;
		logic [1:0]             rresp;
		logic                   rvalid;
	} psrc_axi_rsp_t;

endpackage : psrc_pkg

// ==== psrc_rst_sync.sv ====
// reset synchroniser: asserts at once, releases after two target clock edges
`timescale 1ns/1ps
module psrc_rst_sync
(
	input  wire logic dst_clk_i,
	input  wire logic assert_i,
	output logic      rst_o
);
	import psrc_pkg::*;

	typedef struct packed {
		logic meta;
		logic hold;
	} psrc_sync_t;

	psrc_sync_t st_q;
	psrc_sync_t st_d;

	// meta is read by hold alone
	always_comb
	begin
		st_d.meta = 1'b0;
		st_d.hold = st_q.meta;
	end

	always_ff @(posedge dst_clk_i or posedge assert_i)
	begin
		if (assert_i)
		begin
			st_q <= 2'h3; // [R01]
		end
		else
		begin
			st_q <= st_d; // [R15]
		end
	end

	assign rst_o = st_q.hold;

endmodule : psrc_rst_sync

// ==== psrc_periph_model.sv ====
// peripheral side: one free-running clock per reset line, each at its own rate
`timescale 1ns/1ps
module psrc_periph_model
(
	output logic [psrc_pkg::PSRC_PERIPH_CNT-1:0] periph_clk_o
);
	import psrc_pkg::*;
	// unrelated periods so every release crosses a different phase
	for (genvar g = 0; g < PSRC_PERIPH_CNT; g++)
	begin : g_clk
		initial periph_clk_o[g] = 1'b0;
		always #(2.1 + 0.5 * g) periph_clk_o[g] = ~periph_clk_o[g];
	end
endmodule : psrc_periph_model

// ==== psrc_checker.sv ====
// checker: bus answers and reset line properties of the soft reset block
`timescale 1ns/1ps
module psrc_checker
(
	input wire logic                                 mclk_i,
	input wire logic                                 reset_n_i,
	input wire psrc_pkg::psrc_axi_req_t              axi_req_i,
	input wire psrc_pkg::psrc_axi_rsp_t              axi_rsp_o,
	input wire logic [psrc_pkg::PSRC_PERIPH_CNT-1:0] periph_clk_i,
	input wire logic [psrc_pkg::PSRC_PERIPH_CNT-1:0] periph_rst_o
);
	import psrc_pkg::*;
	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (!reset_n_i);
	sequence s_wr_taken;
		axi_req_i.awvalid && axi_rsp_o.awready && axi_req_i.wvalid && axi_rsp_o.wready;
	endsequence
	sequence s_wr_lo;
		s_wr_taken ##0 (axi_req_i.wstrb[0] && axi_req_i.wdata[1] && axi_req_i.awaddr == PSRC_CTRL_ONE_OFS);
	endsequence
	sequence s_wr_two;
		s_wr_taken ##0 (axi_req_i.wstrb[0] && axi_req_i.wdata[0] && axi_req_i.awaddr == PSRC_CTRL_TWO_OFS);
	endsequence
	property p_wr_lat;
		s_wr_taken |-> ##2 axi_rsp_o.bvalid;
	endproperty
	a_wr_lat: assert property (p_wr_lat) else $error("write answer late");
	property p_rd_lat;
		axi_req_i.arvalid && axi_rsp_o.arready |=> axi_rsp_o.rvalid;
	endproperty
	a_rd_lat: assert property (p_rd_lat) else $error("read answer late");
	property p_b_done;
		axi_rsp_o.bvalid && axi_req_i.bready |=> !axi_rsp_o.bvalid && axi_rsp_o.awready && axi_rsp_o.wready;
	endproperty
	a_b_done: assert property (p_b_done) else $error("write channel not freed");
	property p_aw_block;
		axi_rsp_o.bvalid |-> !axi_rsp_o.awready && !axi_rsp_o.wready;
	endproperty
	a_aw_block: assert property (p_aw_block) else $error("write taken during answer");
	property p_ar_block;
		axi_rsp_o.rvalid |-> !axi_rsp_o.arready;
	endproperty
	a_ar_block: assert property (p_ar_block) else $error("read taken during answer");
	property p_rsvd;
		axi_rsp_o.rvalid |-> (axi_rsp_o.rdata & ~(PSRC_CTRL_ONE_MASK | PSRC_CTRL_TWO_MASK)) == 32'h0;
	endproperty
	a_rsvd: assert property (p_rsvd) else $error("reserved bit read as one");
	property p_set_lo;
		s_wr_lo |-> ##2 periph_rst_o[0];
	endproperty
	a_set_lo: assert property (p_set_lo) else $error("port reset not asserted");
	property p_set_two;
		s_wr_two |-> ##2 periph_rst_o[16];
	endproperty
	a_set_two: assert property (p_set_two) else $error("card reset not asserted");
endmodule : psrc_checker

bind psrc_top psrc_checker u_psrc_checker (.mclk_i(mclk_i), .reset_n_i(reset_n_i), .axi_req_i(axi_req_i),
	.axi_rsp_o(axi_rsp_o), .periph_clk_i(periph_clk_i), .periph_rst_o(periph_rst_o));

// ==== testbench.sv ====
// testbench: register accesses and reset line checks of the soft reset block
`timescale 1ns/1ps
module testbench;
	import psrc_pkg::*;
	logic          mclk_i = 1'b0;
	logic          reset_n_i = 1'b0;
	psrc_axi_req_t req = '0;
	psrc_axi_rsp_t rsp;
	logic [20:0]   pclk;
	logic [20:0]   prst;
	int            errors = 0;
	int            n_tests = 0;
	int            cyc = 0;
	logic [7:0]    a;
	int            pos [21] = '{1, 2, 3, 4, 5, 8, 9, 12, 13, 16, 17, 18, 20, 21, 22, 28, 0, 1, 8, 9, 10};
	always #2.5 mclk_i = ~mclk_i;
	psrc_top u_psrc_top (.mclk_i(mclk_i), .reset_n_i(reset_n_i), .axi_req_i(req), .axi_rsp_o(rsp),
		.periph_clk_i(pclk), .periph_rst_o(prst));
	psrc_periph_model u_psrc_periph_model (.periph_clk_o(pclk));
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", n_tests, errors);
		if (errors == 0 && n_tests > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : end_of_test
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		n_tests++;
		if (g !== e)
		begin
			errors++;
			$display("[ERR] %s expected %h seen %h", n, e, g);
		end
	endtask : chk
	task automatic wr(input logic [7:0] ad, input logic [31:0] v, input logic [3:0] s, input logic [1:0] r);
		@(posedge mclk_i);
		req.awaddr <= ad;
		req.wdata <= v;
		req.wstrb <= s;
		req.awvalid <= 1'b1;
		req.wvalid <= 1'b1;
		req.bready <= 1'b1;
		do
		begin
			@(posedge mclk_i);
			if (rsp.awready === 1'b1)
				req.awvalid <= 1'b0;
			if (rsp.wready === 1'b1)
				req.wvalid <= 1'b0;
		end
		while (rsp.bvalid !== 1'b1);
		req.bready <= 1'b0;
		chk("bresp", 32'(r), 32'(rsp.bresp));
	endtask : wr
	task automatic rd(input logic [7:0] ad, input logic [31:0] e, input logic [1:0] r);
		@(posedge mclk_i);
		req.araddr <= ad;
		req.arvalid <= 1'b1;
		req.rready <= 1'b1;
		do
		begin
			@(posedge mclk_i);
			if (rsp.arready === 1'b1)
				req.arvalid <= 1'b0;
		end
		while (rsp.rvalid !== 1'b1);
		req.rready <= 1'b0;
		chk("rdata", e, rsp.rdata);
		chk("rresp", 32'(r), 32'(rsp.rresp));
	endtask : rd
	// ceiling well above the roughly 1200 cycles the sequence needs
	always @(posedge mclk_i)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			errors++;
			end_of_test();
		end
	end
	initial
	begin
		repeat (8) @(posedge mclk_i);
		chk("rst_in_reset", 32'h001f_ffff, 32'(prst));
		reset_n_i <= 1'b1;
		repeat (20) @(posedge mclk_i);
		chk("rst_idle", 32'h0, 32'(prst));
		rd(PSRC_CTRL_ONE_OFS, 32'h0, PSRC_RESP_OKAY);
		rd(PSRC_CTRL_TWO_OFS, 32'h0, PSRC_RESP_OKAY);
		// one line at a time: a wrong bit position shows as a wrong output
		for (int i = 0; i < 21; i++)
		begin
			a = (i < 16) ? PSRC_CTRL_ONE_OFS : PSRC_CTRL_TWO_OFS;
			wr(a, 32'h1 << pos[i], 4'hf, PSRC_RESP_OKAY);
			repeat (20) @(posedge mclk_i);
			chk("rst_set", 32'h1 << i, 32'(prst));
			wr(a, 32'h0, 4'hf, PSRC_RESP_OKAY);
			repeat (20) @(posedge mclk_i);
			chk("rst_clr", 32'h0, 32'(prst));
		end
		wr(PSRC_CTRL_ONE_OFS, 32'hffff_ffff, 4'h1, PSRC_RESP_OKAY);
		rd(PSRC_CTRL_ONE_OFS, 32'h0000_003e, PSRC_RESP_OKAY);
		wr(PSRC_CTRL_ONE_OFS, 32'hffff_ffff, 4'hf, PSRC_RESP_OKAY);
		wr(PSRC_CTRL_TWO_OFS, 32'hffff_ffff, 4'hf, PSRC_RESP_OKAY);
		rd(PSRC_CTRL_ONE_OFS, 32'h1077_333e, PSRC_RESP_OKAY);
		rd(PSRC_CTRL_TWO_OFS, 32'h0000_0703, PSRC_RESP_OKAY);
		repeat (20) @(posedge mclk_i);
		chk("rst_all", 32'h001f_ffff, 32'(prst));
		rd(PSRC_STAT_ONE_OFS, 32'h1077_333e, PSRC_RESP_OKAY);
		rd(PSRC_STAT_TWO_OFS, 32'h0000_0703, PSRC_RESP_OKAY);
		// status words are read-only: a write there must leave the controls alone
		wr(PSRC_STAT_ONE_OFS, 32'h0, 4'hf, PSRC_RESP_OKAY);
		rd(PSRC_CTRL_ONE_OFS, 32'h1077_333e, PSRC_RESP_OKAY);
		wr(8'h20, 32'hffff_ffff, 4'hf, PSRC_RESP_SLVERR);
		rd(8'h20, 32'h0, PSRC_RESP_SLVERR);
		// release everything so the mid-run reset shows its own assertion
		wr(PSRC_CTRL_ONE_OFS, 32'h0, 4'hf, PSRC_RESP_OKAY);
		wr(PSRC_CTRL_TWO_OFS, 32'h0, 4'hf, PSRC_RESP_OKAY);
		repeat (20) @(posedge mclk_i);
		chk("rst_all_clr", 32'h0, 32'(prst));
		reset_n_i <= 1'b0;
		repeat (3) @(posedge mclk_i);
		chk("rst_sys", 32'h001f_ffff, 32'(prst));
		reset_n_i <= 1'b1;
		rd(PSRC_CTRL_ONE_OFS, 32'h0, PSRC_RESP_OKAY);
		rd(PSRC_CTRL_TWO_OFS, 32'h0, PSRC_RESP_OKAY);
		repeat (20) @(posedge mclk_i);
		chk("rst_idle2", 32'h0, 32'(prst));
		end_of_test();
	end
endmodule : testbench
